/* File: dcc_regs.svh */
// register map constants for the dual comparator control block
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
// printed control register offsets are word indexes; byte address is 4x
`define DCC_IDX_CTRL0 12'hF90
`define DCC_IDX_CTRL1 12'hF91
// block-local registers, byte addresses
`define DCC_ADDR_STATUS 16'h3E48
`define DCC_ADDR_MASK 16'h3E4C
`define DCC_ADDR_POWER 16'h3E50
`define DCC_ADDR_RSTSTAT 16'h3E54
`define DCC_ADDR_IRQREQ 16'h3E58
// reset values
`define DCC_CTRL_RST 8'h14
`define DCC_MASK_RST 2'h0
`define DCC_POWER_RST 4'h0
// AXI responses
`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_SLVERR 2'h2
`endif

/* File: dcc_pkg.sv */
// types shared by the comparator control top and its channel module
// assumes dcc_regs.svh carries all numeric constants except the trigger codes defined here
package dcc_pkg;
    // timer trigger routing codes
    typedef enum logic [1:0] {
        DCC_TRG_NONE = 2'b00,
        DCC_TRG_T0 = 2'b01,
        DCC_TRG_T1 = 2'b10,
        DCC_TRG_T2 = 2'b11
    } dcc_trg_e;
    // one comparator control byte, msb first
    typedef struct packed {
        logic pos_sel;
        logic neg_sel;
        logic [3:0] ref_level;
        dcc_trg_e trg;
    } dcc_ctrl_s;
    // whole state of the top module
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [15:0] awaddr;
        logic [7:0] wbyte;
        logic wen;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        dcc_ctrl_s [1:0] ctrl;
        logic [1:0] status;
        logic [1:0] mask;
        logic [3:0] power;
        logic stop_flag;
        logic req_flag;
        logic recover;
    } dcc_top_s;
    // whole state of one comparator channel
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
        logic level;
        logic evt;
        logic [2:0] trig;
    } dcc_chan_s;
endpackage

/* File: dcc_chan_if.sv */
// carrier between the control top and one comparator channel
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface dcc_chan_if;
    import dcc_pkg::*;
    dcc_ctrl_s cfg;
    logic run;
    logic level;
    logic evt;
    logic [2:0] trig;
    modport ctl (output cfg, output run, input level, input evt, input trig);
    modport chan (input cfg, input run, output level, output evt,
        output trig);
endinterface

/* File: dcc_chan.sv */
// one comparator channel: synchroniser, change detect, timer routing
// assumes cmp_async is the raw analog comparator output, any timing
`timescale 1ns/1ps
module dcc_chan
    import dcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic cmp_async,
    dcc_chan_if.chan bus
);
    dcc_chan_s s_r;
    dcc_chan_s s_nxt;

    // one-hot timer trigger from routing code and level
    function automatic logic [2:0] route(input dcc_trg_e t, input logic lv);
        unique case (t)
            DCC_TRG_NONE: route = 3'h0;
            DCC_TRG_T0: route = {2'h0, lv};
            DCC_TRG_T1: route = {1'h0, lv, 1'h0};
            DCC_TRG_T2: route = {lv, 2'h0};
        endcase
    endfunction

    // sync1 feeds only sync2; changes are judged on sync2 only
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = cmp_async;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.last = s_r.sync2;
        s_nxt.level = s_r.sync2;
        s_nxt.evt = bus.run & (s_r.sync2 ^ s_r.last);
        // a powered-down comparator drives no trigger
        s_nxt.trig = bus.run ? route(bus.cfg.trg, s_r.sync2) : 3'h0;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign bus.level = s_r.level;
    assign bus.evt = s_r.evt;
    assign bus.trig = s_r.trig;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_trig_route: assert property (ce |=>
        s_r.trig == ($past(bus.run) ?
        route($past(bus.cfg.trg), $past(s_r.sync2)) : 3'h0))
        else $error("timer trigger routing wrong");
    chk_event_change: assert property (
        (ce && bus.run && s_r.sync2 != s_r.last) |=> s_r.evt)
        else $error("synchronised change produced no event");
    cov_chan_event: cover property (s_r.evt && s_r.trig != 3'h0);
endmodule // dcc_chan

/* File: dcc_top.sv */
// dual comparator control: AXI4-Lite registers, events, stop recovery
// assumes cmp_raw is asynchronous; stop_mode and int_global_en come from
// logic on clk; analog core, timers and pin mux sit outside
//
// Contract
// - positive select bit: 0 picks GPIO pin, 1 picks temperature sensor
// - negative select: 0 GPIO pin, reference off; 1 reference on and used
// - 4-bit reference level, 0.2 V steps to code 9, resets to 0101
// - reference level per comparator, independent of ADC reference choice
// - trigger field 00 none; 01, 10, 11 drive timer 0, 1, 2
// - comparator 1 register one index above, same fields and codes
// - in stop, enabled comparator interrupt starts recovery and requests
// - comparator stop recovery sets the stop bit in reset status
// - such an event also sets the comparator interrupt request bit
// - after recovery, with interrupts enabled, vector fetch is requested
// - each comparator powers down or keeps running in stop, by power bits
// - comparator output serves as interrupt source or pin output
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_top
    import dcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [15:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [1:0] cmp_raw,
    input wire logic stop_mode,
    input wire logic int_global_en,
    output logic [1:0] pos_sel,
    output logic [1:0] neg_sel,
    output logic [1:0] ref_en,
    output logic [3:0] ref_level0,
    output logic [3:0] ref_level1,
    output logic [2:0] timer_trig,
    output logic [1:0] cmp_pin_out,
    output logic [1:0] cmp_power_on,
    output logic irq,
    output logic stop_recover,
    output logic stop_flag,
    output logic vector_fetch
);
    dcc_top_s s_r;
    dcc_top_s s_nxt;
    dcc_chan_if ch0 ();
    dcc_chan_if ch1 ();
    logic [1:0] run;
    logic [1:0] ev;
    logic [1:0] hit;
    logic ar_take;
    logic do_wr;

    // byte address of a printed word index
    function automatic logic [15:0] word_addr(input logic [11:0] idx);
        word_addr = {2'h0, idx, 2'h0};
    endfunction

    // read value and hit flag for one address; unmapped gives a miss
    function automatic logic [32:0] rd_word(input logic [15:0] a,
        input dcc_top_s s);
        rd_word = {1'b1, 32'h0};
        if (a == word_addr(`DCC_IDX_CTRL0)) begin
            rd_word[7:0] = s.ctrl[0];
        end else if (a == word_addr(`DCC_IDX_CTRL1)) begin
            rd_word[7:0] = s.ctrl[1];
        end else if (a == `DCC_ADDR_STATUS) begin
            rd_word[1:0] = s.status;
        end else if (a == `DCC_ADDR_MASK) begin
            rd_word[1:0] = s.mask;
        end else if (a == `DCC_ADDR_POWER) begin
            rd_word[3:0] = s.power;
        end else if (a == `DCC_ADDR_RSTSTAT) begin
            rd_word[0] = s.stop_flag;
        end else if (a == `DCC_ADDR_IRQREQ) begin
            rd_word[0] = s.req_flag;
        end else begin
            rd_word[32] = 1'b0;
        end
    endfunction

    // a comparator runs when powered, and in stop only if told to stay on
    assign run[0] = s_r.power[0] & (~stop_mode | s_r.power[2]);
    assign run[1] = s_r.power[1] & (~stop_mode | s_r.power[3]);

    // channel hookup; both channels share one channel module
    assign ch0.cfg = s_r.ctrl[0];
    assign ch1.cfg = s_r.ctrl[1];
    assign ch0.run = run[0];
    assign ch1.run = run[1];
    assign ev = {ch1.evt, ch0.evt};
    // only unmasked events may wake the device or raise a request
    assign hit = ev & s_r.mask;

    dcc_chan u_ch0 (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .cmp_async(cmp_raw[0]),
        .bus(ch0)
    );

    dcc_chan u_ch1 (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .cmp_async(cmp_raw[1]),
        .bus(ch1)
    );

    // bus handshakes: one write and one read in flight at a time
    // ready is withheld while frozen, else a handshake would be lost
    assign awready = ce & ~s_r.aw_got & ~s_r.bvalid;
    assign wready = ce & ~s_r.w_got & ~s_r.bvalid;
    assign arready = ce & ~s_r.rvalid;
    assign ar_take = arvalid & arready;
    assign do_wr = s_r.aw_got & s_r.w_got;

    // next state: bus slave, register writes, sticky events
    always_comb begin
        logic [32:0] rd;
        logic [1:0] rd_clr_status;
        logic rd_clr_stop;
        logic rd_clr_req;
        rd = rd_word(araddr, s_r);
        rd_clr_status = 2'h0;
        rd_clr_stop = 1'b0;
        rd_clr_req = 1'b0;
        s_nxt = s_r;
        s_nxt.recover = 1'b0;
        // address and data are taken in either order
        if (awvalid && awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wbyte = wdata[7:0];
            s_nxt.wen = wstrb[0];
        end
        if (do_wr) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `DCC_RESP_OKAY;
            if (s_r.awaddr == word_addr(`DCC_IDX_CTRL0)) begin
                if (s_r.wen) s_nxt.ctrl[0] = dcc_ctrl_s'(s_r.wbyte);
            end else if (s_r.awaddr == word_addr(`DCC_IDX_CTRL1)) begin
                if (s_r.wen) s_nxt.ctrl[1] = dcc_ctrl_s'(s_r.wbyte);
            end else if (s_r.awaddr == `DCC_ADDR_MASK) begin
                if (s_r.wen) s_nxt.mask = s_r.wbyte[1:0];
            end else if (s_r.awaddr == `DCC_ADDR_POWER) begin
                if (s_r.wen) s_nxt.power = s_r.wbyte[3:0];
            end else if (s_r.awaddr == `DCC_ADDR_STATUS ||
                s_r.awaddr == `DCC_ADDR_RSTSTAT ||
                s_r.awaddr == `DCC_ADDR_IRQREQ) begin
                // read-only words accept and ignore writes
                s_nxt.bresp = `DCC_RESP_OKAY;
            end else begin
                s_nxt.bresp = `DCC_RESP_SLVERR;
            end
        end
        // answers drop once the master has taken them
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        // a taken read captures data and clears sticky words it reads
        if (ar_take) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd[31:0];
            s_nxt.rresp = rd[32] ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
            if (araddr == `DCC_ADDR_STATUS) rd_clr_status = 2'h3;
            if (araddr == `DCC_ADDR_RSTSTAT) rd_clr_stop = 1'b1;
            if (araddr == `DCC_ADDR_IRQREQ) rd_clr_req = 1'b1;
        end
        // events set after the clear so a same-cycle event is kept
        s_nxt.status = (s_r.status & ~rd_clr_status) | ev;
        s_nxt.req_flag = (s_r.req_flag & ~rd_clr_req) | (|hit);
        s_nxt.stop_flag = (s_r.stop_flag & ~rd_clr_stop) |
            (stop_mode & (|hit));
        s_nxt.recover = stop_mode & (|hit);
    end

    // state register; reset does not wait for the clock enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.ctrl[0] <= `DCC_CTRL_RST;
            s_r.ctrl[1] <= `DCC_CTRL_RST;
            s_r.mask <= `DCC_MASK_RST;
            s_r.power <= `DCC_POWER_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // register-driven outputs toward the analog core and the pin mux
    assign pos_sel = {s_r.ctrl[1].pos_sel, s_r.ctrl[0].pos_sel};
    assign neg_sel = {s_r.ctrl[1].neg_sel, s_r.ctrl[0].neg_sel};
    // reference is only powered while it is the negative input
    assign ref_en = neg_sel;
    // each level drives its own ladder; no ADC reference input exists
    assign ref_level0 = s_r.ctrl[0].ref_level;
    assign ref_level1 = s_r.ctrl[1].ref_level;
    assign timer_trig = ch0.trig | ch1.trig;
    assign cmp_pin_out = {ch1.level, ch0.level};
    assign cmp_power_on = run;
    assign irq = |(s_r.status & s_r.mask);
    assign stop_recover = s_r.recover;
    assign stop_flag = s_r.stop_flag;
    // the cpu fetches the vector only once awake and interrupts enabled
    assign vector_fetch = s_r.req_flag & int_global_en & ~stop_mode;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_ctrl_reset: assert property ($rose(rst_b) |->
        s_r.ctrl[0] == `DCC_CTRL_RST && s_r.ctrl[1] == `DCC_CTRL_RST)
        else $error("control reset value wrong");
    chk_pos_write: assert property ((ce && do_wr && s_r.wen &&
        s_r.awaddr == word_addr(`DCC_IDX_CTRL0)) |=>
        pos_sel[0] == $past(s_r.wbyte[7]) && bvalid)
        else $error("positive select not written");
    chk_ref_follow: assert property ((ce && do_wr && s_r.wen &&
        s_r.awaddr == word_addr(`DCC_IDX_CTRL1)) |=>
        ref_en[1] == $past(s_r.wbyte[6]) && neg_sel == ref_en)
        else $error("reference enable does not follow negative select");
    chk_ctrl1_write: assert property ((ce && do_wr && s_r.wen &&
        s_r.awaddr == word_addr(`DCC_IDX_CTRL1)) |=>
        ref_level1 == $past(s_r.wbyte[5:2]) &&
        ref_level0 == $past(ref_level0))
        else $error("comparator 1 level write wrong");
    chk_stop_wake: assert property ((ce && stop_mode && |hit) |=>
        stop_recover ##1 (!$past(ce) || !stop_recover || $past(|hit)))
        else $error("stop recovery not started");
    chk_stop_bit: assert property ((ce && stop_mode && |hit) |=>
        stop_flag && irq)
        else $error("stop bit not set");
    chk_req_bit: assert property ((ce && |hit) |=> s_r.req_flag)
        else $error("request bit not set");
    chk_vector: assert property (vector_fetch |->
        int_global_en && !stop_mode && s_r.req_flag)
        else $error("vector fetch without cause");
    chk_power_stop: assert property ((stop_mode && !s_r.power[2]) |->
        !cmp_power_on[0])
        else $error("comparator 0 runs in stop");
    chk_status_keep: assert property ((ce && |ev) |=>
        (s_r.status & $past(ev)) == $past(ev))
        else $error("event lost from status");
    chk_irq_raise: assert property ((ce && |hit && !do_wr) |=>
        irq)
        else $error("unmasked event raised no interrupt");
    chk_power_stop1: assert property ((stop_mode &&
        !s_r.power[3]) |-> !cmp_power_on[1])
        else $error("comparator 1 runs in stop");

    // bus side: answers stand until taken, and come one stage late
    chk_bresp_hold: assert property ((bvalid && !bready) |=>
        bvalid && $stable(bresp))
        else $error("write response dropped before it was taken");
    chk_rdata_hold: assert property ((rvalid && !rready) |=>
        rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped before it was taken");
    chk_write_answer: assert property ((ce && do_wr) |=> bvalid)
        else $error("write gave no response");
    chk_read_answer: assert property (ar_take |=> rvalid)
        else $error("read gave no data");
    chk_busy_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("new write taken while a response waits");

    // control words: every field lands as written, reserved codes too
    chk_level_write: assert property ((ce && do_wr && s_r.wen &&
        s_r.awaddr == word_addr(`DCC_IDX_CTRL0)) |=>
        ref_level0 == $past(s_r.wbyte[5:2]))
        else $error("comparator 0 reference level not written");
    chk_pos1_write: assert property ((ce && do_wr && s_r.wen &&
        s_r.awaddr == word_addr(`DCC_IDX_CTRL1)) |=>
        pos_sel[1] == $past(s_r.wbyte[7]) && bresp == `DCC_RESP_OKAY)
        else $error("comparator 1 positive select not written");
    chk_ctrl0_only: assert property ((ce && do_wr && s_r.wen &&
        s_r.awaddr == word_addr(`DCC_IDX_CTRL0)) |=>
        ref_level1 == $past(ref_level1) && pos_sel[1] == $past(pos_sel[1]))
        else $error("comparator 0 write touched comparator 1");
    chk_read_ctrl: assert property ((ar_take &&
        araddr == word_addr(`DCC_IDX_CTRL1)) |=>
        rdata[7:0] == $past(s_r.ctrl[1]) && rresp == `DCC_RESP_OKAY)
        else $error("comparator 1 word read back wrong");
    chk_power_write: assert property ((ce && do_wr && s_r.wen &&
        s_r.awaddr == `DCC_ADDR_POWER) |=>
        s_r.power == $past(s_r.wbyte[3:0]))
        else $error("power bits not written");
    chk_trig_off: assert property ((ce &&
        s_r.ctrl[0].trg == DCC_TRG_NONE && s_r.ctrl[1].trg == DCC_TRG_NONE)
        |=> timer_trig == 3'h0)
        else $error("timer trigger without a route");

    // sticky words: a read clears them unless an event lands at once
    chk_status_clear: assert property ((ar_take &&
        araddr == `DCC_ADDR_STATUS && !(|ev)) |=> s_r.status == 2'h0)
        else $error("status not cleared by its read");
    chk_req_clear: assert property ((ar_take &&
        araddr == `DCC_ADDR_IRQREQ && !(|hit)) |=> !s_r.req_flag)
        else $error("request bit not cleared by its read");
    chk_stop_clear: assert property ((ar_take &&
        araddr == `DCC_ADDR_RSTSTAT && !(|hit)) |=> !stop_flag)
        else $error("stop bit not cleared by its read");

    // recovery only out of stop, and nothing moves while frozen
    chk_awake_quiet: assert property ((ce && !stop_mode) |=>
        !stop_recover)
        else $error("stop recovery outside stop");
    chk_ce_freeze: assert property (!ce |=> $stable(s_r))
        else $error("state moved while the clock enable was low");

    cov_write_ctrl: cover property (do_wr ##[1:4] bvalid && bready);
    cov_read_status: cover property (ar_take && araddr == `DCC_ADDR_STATUS);
    cov_stop_wake: cover property (stop_recover ##[1:20] vector_fetch);
    cov_unmapped: cover property (rvalid && rresp == `DCC_RESP_SLVERR);
endmodule // dcc_top

/* File: dcc_partner.sv */
// model of the analog comparator cores that feed the control block
// assumes the bench commands each comparator level; outputs are async
`timescale 1ns/1ps
module dcc_partner (
    input wire logic [1:0] want,
    input wire logic slow,
    output logic [1:0] cmp_raw
);
    // outputs settle off the clock grid, promptly or after a long
    // propagation delay, so the block must synchronise them
    initial cmp_raw = 2'b00;
    always @(want) begin
        cmp_raw <= #(slow ? 37 : 3) want;
    end
endmodule // dcc_partner

/* File: dcc_top_bench.sv */
// self-checking bench for the dual comparator control block
// assumes dcc_pkg, dcc_chan, dcc_top and dcc_partner are compiled first
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dual_comparator_control_bench;
    import dcc_pkg::*;
    localparam logic [15:0] A_C0 = {2'b00, `DCC_IDX_CTRL0, 2'b00};
    localparam logic [15:0] A_C1 = {2'b00, `DCC_IDX_CTRL1, 2'b00};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic stop_mode = 1'b0, int_global_en = 1'b0, slow = 1'b0, ce = 1'b1;
    logic [1:0] want = 2'b00;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, cmp_raw, pos_sel, neg_sel, ref_en;
    logic [1:0] cmp_pin_out, cmp_power_on;
    logic [31:0] rdata, rd;
    logic [3:0] ref_level0, ref_level1;
    logic [2:0] timer_trig;
    logic irq, stop_recover, stop_flag, vector_fetch;
    logic [1:0] rs;
    int err_total = 0, total_checks = 0, cycles = 0, rec_cnt = 0;

    always #5 clk = ~clk;

    dcc_partner dcc_partner_i (.want(want), .slow(slow), .cmp_raw(cmp_raw));

    // bus protection bits are tied: the block ignores them
    dcc_top dcc_top_i (.clk(clk), .rst_b(rst_b), .ce(ce),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .cmp_raw(cmp_raw), .stop_mode(stop_mode),
        .int_global_en(int_global_en), .pos_sel(pos_sel),
        .neg_sel(neg_sel), .ref_en(ref_en), .ref_level0(ref_level0),
        .ref_level1(ref_level1), .timer_trig(timer_trig),
        .cmp_pin_out(cmp_pin_out), .cmp_power_on(cmp_power_on),
        .irq(irq), .stop_recover(stop_recover), .stop_flag(stop_flag),
        .vector_fetch(vector_fetch));

    // count recovery pulses; a hang ends the run through the ceiling
    always @(posedge clk) begin
        cycles++;
        if (stop_recover === 1'b1) rec_cnt++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awready) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge clk);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_bus(input logic [15:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        rd_bus(a);
        chk(rd, exp);
        chk({30'h0, rs}, {30'h0, `DCC_RESP_OKAY});
    endtask

    // analog propagation plus synchroniser and event stages
    task automatic settle();
        repeat (12) @(posedge clk);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdchk(A_C0, 32'h14);
        rdchk(A_C1, 32'h14);
        rdchk(`DCC_ADDR_MASK, 32'h0);
        rdchk(`DCC_ADDR_POWER, 32'h0);
        chk(ref_level0, 32'h5);
        $display("reset values done");
        // top code 1001 and reserved 1111 are stored as written
        wr(A_C0, 8'hA7);
        chk(pos_sel, 32'h1);
        chk(ref_en, 32'h0);
        chk(ref_level0, 32'h9);
        wr(A_C1, 8'h7C);
        chk(neg_sel, 32'h2);
        chk(ref_en, 32'h2);
        chk({ref_level1, ref_level0}, 32'hF9);
        rdchk(A_C1, 32'h7C);
        rdchk(A_C0, 32'hA7);
        wr(16'h3E60, 8'hFF);
        chk(rs, `DCC_RESP_SLVERR);
        rd_bus(16'h3E60);
        chk(rd, 32'h0);
        chk({30'h0, rs}, {30'h0, `DCC_RESP_SLVERR});
        $display("control fields done");
        // masked event sets status only; interrupts stay off meanwhile
        wr(`DCC_ADDR_POWER, 8'h03);
        chk(cmp_power_on, 32'h3);
        want <= 2'b01;
        settle();
        chk(cmp_pin_out, 32'h1);
        chk(irq, 32'h0);
        wr(`DCC_ADDR_MASK, 8'h01);
        chk(irq, 32'h1);
        rdchk(`DCC_ADDR_STATUS, 32'h1);
        chk(irq, 32'h0);
        rdchk(`DCC_ADDR_IRQREQ, 32'h0);
        $display("interrupt mask done");
        for (int k = 0; k < 4; k++) begin
            wr(A_C0, {6'b101001, k[1:0]});
            repeat (2) @(posedge clk);
            chk(timer_trig, (k == 0) ? 32'h0 : 32'h1 << (k - 1));
        end
        want <= 2'b00;
        settle();
        chk(timer_trig, 32'h0);
        rdchk(`DCC_ADDR_STATUS, 32'h1);
        rdchk(`DCC_ADDR_IRQREQ, 32'h1);
        chk(rec_cnt, 32'h0);
        $display("timer routing done");
        // stop: comparator off unless kept running, slow analog answer
        stop_mode <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk(cmp_power_on, 32'h0);
        wr(`DCC_ADDR_POWER, 8'h0F);
        chk(cmp_power_on, 32'h3);
        wr(`DCC_ADDR_MASK, 8'h03);
        slow <= 1'b1;
        want <= 2'b10;
        settle();
        chk(stop_flag, 32'h1);
        chk(rec_cnt, 32'h1);
        chk({irq, vector_fetch}, 32'h2);
        stop_mode <= 1'b0;
        int_global_en <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk(vector_fetch, 32'h1);
        rdchk(`DCC_ADDR_RSTSTAT, 32'h1);
        rdchk(`DCC_ADDR_IRQREQ, 32'h1);
        chk({stop_flag, vector_fetch}, 32'h0);
        rdchk(`DCC_ADDR_STATUS, 32'h2);
        chk(irq, 32'h0);
        $display("stop recovery done");
        // a low clock enable freezes synchronisers and sticky status
        ce <= 1'b0;
        slow <= 1'b0;
        want <= 2'b11;
        settle();
        chk(cmp_pin_out, 32'h2);
        ce <= 1'b1;
        settle();
        chk(cmp_pin_out, 32'h3);
        rdchk(`DCC_ADDR_STATUS, 32'h1);
        $display("clock enable done");
        close_out();
    end
endmodule // dual_comparator_control_bench
